// *** rtl/load_push_defs.vh ***
`ifndef LOAD_PUSH_DEFS_VH
`define LOAD_PUSH_DEFS_VH

// Prefix and opcode bytes.
`define PFX_FIRST_INDEX 8'h_00DD
`define PFX_SECOND_INDEX 8'h_00FD
`define PFX_EXTENDED 8'h_00ED
`define OP_LOAD_DIRECT 8'h_002A
`define OP_STORE_DIRECT 8'h_0022
`define OP_SP_COPY 8'h_00F9
// Extended opcode pattern: bits 7:6 and 3:0, pair field in 5:4.
`define ED_GROUP 2'h_0001
`define ED_STORE_LOW 4'h_0003
`define ED_LOAD_LOW 4'h_000B
// Push opcode: bits 7:6 and 3:0, pair field in 5:4.
`define PUSH_GROUP 2'h_0003
`define PUSH_LOW 4'h_0005

// Machine cycle lengths in clock states.
`define T_FETCH 3'h_0004
`define T_MEM 3'h_0003
`define T_EXT_COPY 3'h_0002
`define T_EXT_PUSH 3'h_0001

// Register file indices.
`define RI_COUNTER 3'h_0000
`define RI_STACK 3'h_0003
`define RI_ACC_FLAGS 3'h_0004
`define RI_FIRST_INDEX 3'h_0005
`define RI_SECOND_INDEX 3'h_0006
`define RI_PROGRAM 3'h_0007

// Reset value of every register.
`define REG_RESET 16'h_0000
`endif

// *** rtl/load_push_unit.v ***
`timescale 1ns/100ps
`include "load_push_defs.vh"
module load_push_unit
(
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_ce,
  input wire i_hold,
  input wire i_load_en,
  input wire [2:0] i_load_sel,
  input wire [15:0] i_load_value,
  input wire [7:0] i_mem_rdata,
  output reg [15:0] o_mem_addr_q,
  output reg o_mem_rd_q,
  output reg o_mem_wr_q,
  output reg o_m1_q,
  output reg [7:0] o_mem_wdata_q,
  output reg o_idle_q,
  output reg o_done_q,
  output reg o_unsupported_q,
  output wire [15:0] o_counter_pair,
  output wire [15:0] o_destination_pair,
  output wire [15:0] o_pointer_pair,
  output wire [15:0] o_stack_pointer,
  output wire [15:0] o_accumulator_flags_pair,
  output wire [15:0] o_first_index_register,
  output wire [15:0] o_second_index_register,
  output wire [15:0] o_program_counter
);

  // Sequencer steps; each step is one machine cycle or an extension of one.
  localparam S_IDLE = 4'd0;
  localparam S_FETCH = 4'd1;
  localparam S_RDLO = 4'd2;
  localparam S_RDHI = 4'd3;
  localparam S_MEM1 = 4'd4;
  localparam S_MEM2 = 4'd5;
  localparam S_EXT = 4'd6;
  localparam S_PUSH1 = 4'd7;
  localparam S_PUSH2 = 4'd8;

  // Prefix codes held between the prefix fetch and the opcode fetch.
  localparam P_NONE = 2'd0;
  localparam P_FIRST = 2'd1;
  localparam P_SECOND = 2'd2;
  localparam P_EXT = 2'd3;

  // Register file: index 0..6 are the pairs, 7 is the program counter.
  reg [15:0] rf_q [0:7];
  // Current step, its state count and its length in clock states.
  reg [3:0] step_q;
  reg [2:0] tcnt_q;
  reg [2:0] mlen_q;
  // Prefix seen, target register, store direction and push marker.
  reg [1:0] pfx_q;
  reg [2:0] tgt_q;
  reg st_q;
  reg push_q;
  // Low byte of the direct address, caught from the first operand.
  reg [7:0] nn_lo_q;

  // Next-step decisions from the combinational decoder.
  reg [3:0] nstep_d;
  reg [2:0] nlen_d;
  reg [1:0] npfx_d;
  reg [2:0] ntgt_d;
  reg nst_d;
  reg npush_d;
  reg ndone_d;
  reg nbad_d;

  wire last_t;
  wire [15:0] sp_dec;
  wire [7:0] op;

  assign last_t = (tcnt_q == mlen_q - 3'd1);
  assign sp_dec = rf_q[`RI_STACK] - 16'h_0001;
  assign op = i_mem_rdata;

  // Architectural registers are visible straight from their flip-flops.
  assign o_counter_pair = rf_q[0];
  assign o_destination_pair = rf_q[1];
  assign o_pointer_pair = rf_q[2];
  assign o_stack_pointer = rf_q[3];
  assign o_accumulator_flags_pair = rf_q[4];
  assign o_first_index_register = rf_q[5];
  assign o_second_index_register = rf_q[6];
  assign o_program_counter = rf_q[7];

  // Decode the step that follows the current machine cycle.
  // Only the fetch step looks at the byte on the bus as an opcode.
  always @*
  begin
    nstep_d = S_FETCH;
    nlen_d = `T_FETCH;
    npfx_d = pfx_q;
    ntgt_d = tgt_q;
    nst_d = st_q;
    npush_d = 1'b0;
    ndone_d = 1'b0;
    nbad_d = 1'b0;
    case (step_q)
      S_IDLE:
      begin
        // Leave idle only when the hold request is released.
        if (i_hold)
        begin
          nstep_d = S_IDLE;
          nlen_d = 3'd1;
        end
      end
      S_FETCH:
      begin
        if (pfx_q == P_NONE && op == `PFX_FIRST_INDEX)
          npfx_d = P_FIRST;
        else if (pfx_q == P_NONE && op == `PFX_SECOND_INDEX)
          npfx_d = P_SECOND;
        else if (pfx_q == P_NONE && op == `PFX_EXTENDED)
          npfx_d = P_EXT;
        else if (pfx_q == P_EXT && op[7:6] == `ED_GROUP && op[3:0] == `ED_STORE_LOW)
        begin
          // Selected pair goes out to the direct address.
          nstep_d = S_RDLO;
          nlen_d = `T_MEM;
          ntgt_d = {1'b0, op[5:4]};
          nst_d = 1'b1;
        end
        else if (pfx_q == P_EXT && op[7:6] == `ED_GROUP && op[3:0] == `ED_LOAD_LOW)
        begin
          // Selected pair is filled from the direct address.
          nstep_d = S_RDLO;
          nlen_d = `T_MEM;
          ntgt_d = {1'b0, op[5:4]};
          nst_d = 1'b0;
        end
        else if ((pfx_q == P_FIRST || pfx_q == P_SECOND)
                 && (op == `OP_LOAD_DIRECT || op == `OP_STORE_DIRECT))
        begin
          // Index register transfer; the second fetch made it 4,4.
          nstep_d = S_RDLO;
          nlen_d = `T_MEM;
          ntgt_d = (pfx_q == P_FIRST) ? `RI_FIRST_INDEX : `RI_SECOND_INDEX;
          nst_d = (op == `OP_STORE_DIRECT);
        end
        else if (pfx_q == P_NONE && op == `OP_STORE_DIRECT)
        begin
          // Unprefixed store of the pointer pair, 4,3,3,3,3.
          nstep_d = S_RDLO;
          nlen_d = `T_MEM;
          ntgt_d = 3'd2;
          nst_d = 1'b1;
        end
        else if (pfx_q != P_EXT && op == `OP_SP_COPY)
        begin
          // Fetch is stretched by two states to make six.
          nstep_d = S_EXT;
          nlen_d = `T_EXT_COPY;
          ntgt_d = (pfx_q == P_FIRST) ? `RI_FIRST_INDEX :
                   (pfx_q == P_SECOND) ? `RI_SECOND_INDEX : 3'd2;
        end
        else if (pfx_q == P_NONE && op[7:6] == `PUSH_GROUP && op[3:0] == `PUSH_LOW)
        begin
          // Fetch is stretched by one state to make five.
          nstep_d = S_EXT;
          nlen_d = `T_EXT_PUSH;
          ntgt_d = (op[5:4] == 2'd3) ? `RI_ACC_FLAGS : {1'b0, op[5:4]};
          npush_d = 1'b1;
        end
        else
        begin
          // Anything outside this group is skipped as a one-cycle no-op.
          ndone_d = 1'b1;
          nbad_d = 1'b1;
        end
      end
      S_RDLO:
      begin
        nstep_d = S_RDHI;
        nlen_d = `T_MEM;
      end
      S_RDHI:
      begin
        nstep_d = S_MEM1;
        nlen_d = `T_MEM;
      end
      S_MEM1:
      begin
        nstep_d = S_MEM2;
        nlen_d = `T_MEM;
      end
      S_EXT:
      begin
        if (push_q)
        begin
          nstep_d = S_PUSH1;
          nlen_d = `T_MEM;
        end
        else
          ndone_d = 1'b1;
      end
      S_PUSH1:
      begin
        nstep_d = S_PUSH2;
        nlen_d = `T_MEM;
      end
      S_MEM2, S_PUSH2:
        ndone_d = 1'b1;
      default:
        ndone_d = 1'b1;
    endcase
    if (ndone_d)
    begin
      npfx_d = P_NONE;
      // A held sequencer parks between instructions, never inside one.
      if (i_hold)
      begin
        nstep_d = S_IDLE;
        nlen_d = 3'd1;
      end
    end
  end

  // Sequencer, bus and register file. All but the state count and the done and unsupported pulses, which drop each state, advance only at the last
  // state of a machine cycle, where the addressed byte is sampled. No flag
  // register is written by any instruction below.
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      step_q <= S_IDLE;
      tcnt_q <= 3'd0;
      mlen_q <= 3'd1;
      pfx_q <= P_NONE;
      tgt_q <= `RI_COUNTER;
      st_q <= 1'b0;
      push_q <= 1'b0;
      nn_lo_q <= 8'h_0000;
      o_mem_addr_q <= 16'h_0000;
      o_mem_rd_q <= 1'b0;
      o_mem_wr_q <= 1'b0;
      o_m1_q <= 1'b0;
      o_mem_wdata_q <= 8'h_0000;
      o_idle_q <= 1'b1;
      o_done_q <= 1'b0;
      o_unsupported_q <= 1'b0;
      rf_q[0] <= `REG_RESET;
      rf_q[1] <= `REG_RESET;
      rf_q[2] <= `REG_RESET;
      rf_q[3] <= `REG_RESET;
      rf_q[4] <= `REG_RESET;
      rf_q[5] <= `REG_RESET;
      rf_q[6] <= `REG_RESET;
      rf_q[7] <= `REG_RESET;
    end
    else if (i_ce)
    begin
      o_done_q <= 1'b0;
      o_unsupported_q <= 1'b0;
      if (!last_t)
        tcnt_q <= tcnt_q + 3'd1;
      else
      begin
        // Effects of the machine cycle that ends now.
        case (step_q)
          S_IDLE:
            if (i_load_en)
              rf_q[i_load_sel] <= i_load_value;
          S_RDLO:
            nn_lo_q <= i_mem_rdata;
          S_MEM1:
            if (!st_q)
              rf_q[tgt_q][7:0] <= i_mem_rdata;
          S_MEM2:
            if (!st_q)
              rf_q[tgt_q][15:8] <= i_mem_rdata;
          S_EXT:
            if (!push_q)
              rf_q[`RI_STACK] <= rf_q[tgt_q];
          default:
            tcnt_q <= 3'd0;
        endcase
        tcnt_q <= 3'd0;
        step_q <= nstep_d;
        mlen_q <= nlen_d;
        pfx_q <= npfx_d;
        tgt_q <= ntgt_d;
        st_q <= nst_d;
        push_q <= (step_q == S_FETCH) ? npush_d : push_q;
        o_done_q <= ndone_d;
        o_unsupported_q <= nbad_d;
        o_idle_q <= (nstep_d == S_IDLE);
        o_mem_rd_q <= 1'b0;
        o_mem_wr_q <= 1'b0;
        o_m1_q <= 1'b0;
        // Bus set-up for the machine cycle that starts now.
        case (nstep_d)
          S_FETCH, S_RDLO, S_RDHI:
          begin
            // Prefix, opcode and operands come from successive addresses.
            o_mem_addr_q <= rf_q[`RI_PROGRAM];
            o_mem_rd_q <= 1'b1;
            o_m1_q <= (nstep_d == S_FETCH);
            rf_q[`RI_PROGRAM] <= rf_q[`RI_PROGRAM] + 16'h_0001;
          end
          S_MEM1:
          begin
            // Second operand is the high byte of the address.
            o_mem_addr_q <= {i_mem_rdata, nn_lo_q};
            o_mem_rd_q <= !st_q;
            o_mem_wr_q <= st_q;
            o_mem_wdata_q <= rf_q[tgt_q][7:0];
          end
          S_MEM2:
          begin
            // High byte always goes to the next address up.
            o_mem_addr_q <= o_mem_addr_q + 16'h_0001;
            o_mem_rd_q <= !st_q;
            o_mem_wr_q <= st_q;
            o_mem_wdata_q <= rf_q[tgt_q][15:8];
          end
          S_PUSH1, S_PUSH2:
          begin
            // Decrement first, then write: high byte, then low byte.
            o_mem_addr_q <= sp_dec;
            rf_q[`RI_STACK] <= sp_dec;
            o_mem_wr_q <= 1'b1;
            o_mem_wdata_q <= (nstep_d == S_PUSH1) ? rf_q[tgt_q][15:8] : rf_q[tgt_q][7:0];
          end
          default:
            o_mem_wr_q <= 1'b0;
        endcase
      end
    end
  end

endmodule

// *** bench/load_push_unit_chk.sv ***
`timescale 1ns/100ps
// Watches bus timing and register side effects at the unit's ports.
module load_push_chk
(
  input wire i_ref_clk,
  input wire i_reset,
  input wire [15:0] o_mem_addr_q,
  input wire o_mem_rd_q,
  input wire o_mem_wr_q,
  input wire o_m1_q,
  input wire o_done_q,
  input wire o_idle_q,
  input wire [15:0] o_stack_pointer,
  input wire [15:0] o_accumulator_flags_pair
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // A fetch lasts four states and keeps its address, since memory has no waits.
  fetch_hold_a: assert property ($rose(o_m1_q) |-> o_m1_q[*4] and ##1 $stable(o_mem_addr_q)[*3])
    else $error("fetch cycle shape wrong");
  fetch_read_a: assert property (o_m1_q |-> o_mem_rd_q && !o_mem_wr_q)
    else $error("fetch without read strobe");
  // Direct transfers: two operand reads, then two data reads or writes, then done.
  xfer_shape_a: assert property ($fell(o_m1_q) && o_mem_rd_q |->
    o_mem_rd_q[*6] ##1 (o_mem_rd_q[*6] or o_mem_wr_q[*6]) ##1 o_done_q)
    else $error("direct transfer timing wrong");
  write_len_a: assert property ($rose(o_mem_wr_q) |-> o_mem_wr_q[*6] ##1 !o_mem_wr_q)
    else $error("write pair length wrong");
  store_addr_a: assert property ($rose(o_mem_wr_q) && $past(o_mem_rd_q) |->
    ##3 o_mem_addr_q == $past(o_mem_addr_q, 3) + 16'h0001)
    else $error("store high byte address wrong");
  // A push writes after one idle state, high byte first, then one address lower.
  push_addr_a: assert property ($rose(o_mem_wr_q) && !$past(o_mem_rd_q) |->
    $past(o_m1_q, 2) && !$past(o_m1_q) ##3 o_mem_addr_q == $past(o_mem_addr_q, 3) - 16'h0001)
    else $error("push order or gap wrong");
  // Parking after a fetch also drops the fetch strobe with no bus strobe, so idle is excluded.
  copy_len_a: assert property ($fell(o_m1_q) && !o_mem_rd_q && !o_mem_wr_q && !o_idle_q |=>
    o_mem_wr_q or (!o_mem_wr_q ##1 o_done_q))
    else $error("copy extension length wrong");
  push_sp_a: assert property ($fell(o_mem_wr_q) && $past(o_mem_addr_q) + 16'h0001 == $past(o_mem_addr_q, 4)
    |-> o_stack_pointer == $past(o_mem_addr_q))
    else $error("stack pointer after push wrong");
  flags_kept_a: assert property (!o_idle_q |=> $stable(o_accumulator_flags_pair))
    else $error("flags changed by instruction");
endmodule
bind load_push_unit load_push_chk u_chk (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .o_mem_addr_q(o_mem_addr_q),
  .o_mem_rd_q(o_mem_rd_q), .o_mem_wr_q(o_mem_wr_q), .o_m1_q(o_m1_q), .o_done_q(o_done_q), .o_idle_q(o_idle_q),
  .o_stack_pointer(o_stack_pointer), .o_accumulator_flags_pair(o_accumulator_flags_pair));

// *** bench/mem_model.sv ***
`timescale 1ns/100ps
// Byte-wide memory that answers in the same state, as the bus has no waits.
module mem_model
(
  input wire i_clk,
  input wire [15:0] i_addr,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_wdata,
  output wire [7:0] o_rdata
);
  reg [7:0] mem [0:65535]; // Cleared, so spare fetches decode as no-ops.
  integer i;
  // Start from a known empty memory.
  initial
  begin
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = 8'h00;
  end
  // A released bus shows a changing pattern, so a stale byte cannot pass.
  assign o_rdata = i_rd ? mem[i_addr] : ~i_addr[7:0];
  // A write lands while the strobe is up.
  always @(posedge i_clk)
  begin
    if (i_wr)
      mem[i_addr] <= i_wdata;
  end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  reg i_ref_clk = 1'b0; // Clock at 100 MHz.
  reg i_reset = 1'b1; // Held for the first twelve cycles.
  reg i_ce = 1'b1; // Kept on; freezing is outside these checks.
  reg i_hold = 1'b1; // Parks the unit while registers are preset.
  reg i_load_en = 1'b0;
  reg [2:0] i_load_sel = 3'h0;
  reg [15:0] i_load_value = 16'h0000;
  wire [7:0] rdata;
  wire [7:0] wdata;
  wire [15:0] addr;
  wire rd, wr, m1, idle, done, unsup;
  wire [127:0] rf; // All eight registers, selected by index times sixteen.
  integer failures = 0;
  integer n_compared = 0;
  integer k;
  load_push_unit DUT
  (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(i_ce), .i_hold(i_hold), .i_load_en(i_load_en),
    .i_load_sel(i_load_sel), .i_load_value(i_load_value), .i_mem_rdata(rdata), .o_mem_addr_q(addr),
    .o_mem_rd_q(rd), .o_mem_wr_q(wr), .o_m1_q(m1), .o_mem_wdata_q(wdata), .o_idle_q(idle), .o_done_q(done),
    .o_unsupported_q(unsup), .o_counter_pair(rf[15:0]), .o_destination_pair(rf[31:16]), .o_pointer_pair(rf[47:32]),
    .o_stack_pointer(rf[63:48]), .o_accumulator_flags_pair(rf[79:64]), .o_first_index_register(rf[95:80]),
    .o_second_index_register(rf[111:96]), .o_program_counter(rf[127:112])
  );
  mem_model M (.i_clk(i_ref_clk), .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata));
  // Free-running clock.
  initial
  forever #5 i_ref_clk = ~i_ref_clk;
  // Verdict, reached from the main sequence and from the watchdog.
  task final_report;
  begin
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task chk(input [8*5:1] what, input [15:0] exp, input [15:0] got);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("BAD %0s exp %h got %h", what, exp, got);
    end
  end
  endtask
  // Lets an edge pass and its updates settle before sampling.
  task step;
  begin
    @(posedge i_ref_clk);
    #1;
  end
  endtask
  // Presets one register through the load port while parked.
  task pre(input [2:0] sel, input [15:0] val);
  begin
    @(posedge i_ref_clk);
    i_load_en <= 1'b1;
    i_load_sel <= sel;
    i_load_value <= val;
    @(posedge i_ref_clk);
    i_load_en <= 1'b0;
  end
  endtask
  task prog(input [7:0] b0, b1, b2, b3);
  begin
    {M.mem[0], M.mem[1], M.mem[2], M.mem[3]} = {b0, b1, b2, b3};
  end
  endtask
  // Runs the program at zero and counts states from first fetch to done.
  task run(input [15:0] len);
    integer n;
  begin
    pre(3'h7, 16'h0000);
    @(posedge i_ref_clk) i_hold <= 1'b0;
    for (n = 0; rd !== 1'b1 && n < 40; n = n + 1) step;
    for (n = 0; done !== 1'b1 && n < 40; n = n + 1) step;
    chk("state", len, n[15:0]);
    chk("bad", 16'h0000, {15'h0000, unsup});
    // The trailing zero byte is a no-op, so parking after it is harmless.
    // The pause lets the finished pulse drop before the no-op's own pulse is awaited.
    @(posedge i_ref_clk) i_hold <= 1'b1;
    #1;
    for (n = 0; done !== 1'b1 && n < 40; n = n + 1) step;
    chk("nop", 16'h0001, {15'h0000, unsup});
    for (n = 0; idle !== 1'b1 && n < 40; n = n + 1) step;
    chk("idle", 16'h0001, {15'h0000, idle});
  end
  endtask
  // Index loads and every load pair field through the extended load.
  task t_load;
    reg [2:0] sel;
  begin
    for (k = 0; k < 6; k = k + 1)
    begin
      sel = (k < 2) ? 3'h5 + k[2:0] : k[2:0] - 3'h2;
      {M.mem[16'h2000], M.mem[16'h2001]} = {8'h10 + k[7:0], 8'ha0 + k[7:0]};
      prog((k == 0) ? 8'hdd : (k == 1) ? 8'hfd : 8'hed, (k < 2) ? 8'h2a : 8'h4b + {k[1:0] - 2'h2, 4'h0}, 8'h00, 8'h20);
      run(16'h0014);
      chk("load", {8'ha0 + k[7:0], 8'h10 + k[7:0]}, rf[{sel, 4'h0} +: 16]);
      chk("pc", 16'h0005, rf[127:112]);
    end
  end
  endtask
  // Pointer pair, both index registers and every pair field stored at nn.
  task t_store;
    reg [2:0] sel;
    reg [15:0] v;
    reg [15:0] nn;
  begin
    for (k = 0; k < 7; k = k + 1)
    begin
      sel = (k == 0) ? 3'h2 : (k < 3) ? 3'h4 + k[2:0] : k[2:0] - 3'h3;
      v = {8'hb0 + k[7:0], 8'h40 + k[7:0]};
      nn = {8'h30, k[5:0], 2'h0};
      pre(sel, v);
      if (k == 0)
        prog(8'h22, nn[7:0], nn[15:8], 8'h00);
      else
        prog((k == 1) ? 8'hdd : (k == 2) ? 8'hfd : 8'hed, (k < 3) ? 8'h22 : 8'h43 + {k[1:0] + 2'h1, 4'h0}, nn[7:0], nn[15:8]);
      run((k == 0) ? 16'h0010 : 16'h0014);
      chk("lo", {8'h00, v[7:0]}, {8'h00, M.mem[nn]});
      chk("hi", {8'h00, v[15:8]}, {8'h00, M.mem[nn + 16'h0001]});
      chk("pc", (k == 0) ? 16'h0004 : 16'h0005, rf[127:112]);
    end
  end
  endtask
  // Stack pointer copies from the pointer pair and both index registers.
  task t_copy;
  begin
    for (k = 0; k < 3; k = k + 1)
    begin
      pre(3'h3, 16'h0000);
      pre((k == 0) ? 3'h2 : 3'h4 + k[2:0], 16'h9c00 + k[15:0]);
      prog((k == 0) ? 8'hf9 : (k == 1) ? 8'hdd : 8'hfd, (k == 0) ? 8'h00 : 8'hf9, 8'h00, 8'h00);
      run((k == 0) ? 16'h0006 : 16'h000a);
      chk("sp", 16'h9c00 + k[15:0], rf[63:48]);
      chk("pc", (k == 0) ? 16'h0002 : 16'h0003, rf[127:112]);
    end
  end
  endtask
  // Push of every stack pair field value; the flags pair was preset at start.
  task t_push;
    reg [15:0] v;
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      v = (k == 3) ? 16'h7e81 : {8'h60 + k[7:0], 8'h20 + k[7:0]};
      if (k < 3)
        pre(k[2:0], v);
      pre(3'h3, 16'h1007);
      prog(8'hc5 + {k[1:0], 4'h0}, 8'h00, 8'h00, 8'h00);
      run(16'h000b);
      chk("hi", {8'h00, v[15:8]}, {8'h00, M.mem[16'h1006]});
      chk("lo", {8'h00, v[7:0]}, {8'h00, M.mem[16'h1005]});
      chk("sp", 16'h1005, rf[63:48]);
      chk("pc", 16'h0002, rf[127:112]);
    end
  end
  endtask
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    pre(3'h4, 16'h7e81);
    t_load;
    t_store;
    t_copy;
    t_push;
    chk("flags", 16'h7e81, rf[79:64]);
    final_report;
  end
  // Watchdog well beyond the fewer than one thousand cycles the tests need.
  initial
  begin
    #200000;
    failures = failures + 1;
    final_report;
  end
endmodule
